// ===== spi_ctrl.v
// Serial controller, master or slave, with an 8-bit APB register port
`timescale 1ns/1ns
`include "spi_defs.vh"
module spi_ctrl
(
    // System clock and reset
    input  wire       clk,
    input  wire       nrst,
    // APB register port
    input  wire       psel,
    input  wire       penable,
    input  wire       pwrite,
    input  wire [3:0] paddr,
    input  wire [7:0] pwdata,
    output reg  [7:0] prdata,
    // Flag and interrupt outputs
    output wire       tx_reg_empty,
    output wire       rx_data_ready,
    output wire       irq,
    output wire       master_mode,
    // Master side pins
    input  wire       m_miso,
    output reg        m_mosi,
    output reg        m_sck,
    output reg  [7:0] m_sel_n,
    // Slave side pins
    input  wire       s_sck,
    input  wire       s_sel_n,
    input  wire       s_mosi,
    output reg        s_miso,
    output wire       s_miso_oe_n
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LEAD = 3'b010;
    localparam [2:0] ST_XFER = 3'b100;

    reg  [7:0] cfg_ff;
    reg  [7:0] sel_mask_ff;
    reg        enable_ff;
    reg        error_ff;
    reg  [7:0] tx_hold_ff;
    reg        tx_empty_ff;
    reg  [7:0] rx_hold_ff;
    reg        rx_ready_ff;
    reg  [7:0] shift_ff;
    reg  [3:0] bit_cnt_ff;
    reg  [2:0] state_ff;
    reg        sck_phase_ff;
    reg  [2:0] s_sck_sync_ff;
    reg  [1:0] s_sel_sync_ff;
    reg  [1:0] s_mosi_sync_ff;
    reg  [1:0] m_miso_sync_ff;
    reg  [2:0] s_sel_hist_ff;
    reg  [2:0] samp_dly_ff;
    reg  [7:0] rx_shift_ff;
    reg  [2:0] rx_cnt_ff;
    reg        tx_load;

    wire       wr_en;
    wire       rd_data;
    wire       is_master;
    wire       half_tick;
    wire       busy;
    wire       char_done;
    wire [7:0] rx_char;
    wire       s_sel_act;
    wire       s_rise;
    wire       s_fall;
    wire       s_lead;
    wire       s_trail;
    wire       s_start;
    wire       cpha;
    wire       lsb;
    wire       in_bit;
    wire       out_bit;
    wire       samp_now;
    wire       rx_strobe;
    wire       rx_capture;

    assign wr_en   = psel && penable && pwrite;
    assign rd_data = psel && penable && !pwrite && (paddr == `ADDR_DATA);
    assign is_master = cfg_ff[`CFG_MASTER];
    assign master_mode = is_master;
    assign cpha = cfg_ff[`CFG_CPHA];
    assign lsb  = cfg_ff[`CFG_LSB_FIRST];
    assign busy = (state_ff != ST_IDLE);

    // Flag outputs are level copies of the status flags
    assign tx_reg_empty  = tx_empty_ff;
    assign rx_data_ready = rx_ready_ff;
    assign irq = cfg_ff[`CFG_IRQ_EN] && (tx_empty_ff || rx_ready_ff);

    // Serial bit order: the outgoing bit and the receive shift direction
    assign out_bit = lsb ? shift_ff[0] : shift_ff[7];
    // Divider runs only while the master is active
    clk_divider u_div
    (
        .clk       (clk),
        .nrst      (nrst),
        .run       (busy && is_master),
        .rate      (cfg_ff[`CFG_RATE_HI:0]),
        .half_tick (half_tick)
    );

    // Pin synchronisers; first stage feeds only the second
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_sck_sync_ff  <= 3'b000;
            s_sel_sync_ff  <= 2'b11;
            s_mosi_sync_ff <= 2'b00;
            m_miso_sync_ff <= 2'b00;
            s_sel_hist_ff  <= 3'b111;
        end
        else
        begin
            s_sck_sync_ff  <= {s_sck_sync_ff[1:0], s_sck};
            s_sel_sync_ff  <= {s_sel_sync_ff[0], s_sel_n};
            s_mosi_sync_ff <= {s_mosi_sync_ff[0], s_mosi};
            m_miso_sync_ff <= {m_miso_sync_ff[0], m_miso};
            s_sel_hist_ff  <= {s_sel_hist_ff[1:0], s_sel_sync_ff[1]};
        end
    end

    // Edge detection looks only at synchronised stages 2 and 3
    assign s_rise    = s_sck_sync_ff[1] && !s_sck_sync_ff[2];
    assign s_fall    = !s_sck_sync_ff[1] && s_sck_sync_ff[2];
    assign s_sel_act = !s_sel_sync_ff[1];
    assign s_start   = s_sel_act && s_sel_hist_ff[0];
    // Leading edge is rise for idle-low clock; phase picks sample edge
    assign s_lead  = s_sel_act && (cfg_ff[`CFG_CPOL] ? s_fall : s_rise);
    assign s_trail = s_sel_act && (cfg_ff[`CFG_CPOL] ? s_rise : s_fall);
    assign in_bit  = is_master ? m_miso_sync_ff[1] : s_mosi_sync_ff[1];

    // A character completes after the eighth sample
    assign char_done = (bit_cnt_ff == `CHAR_BITS);

    // Sample strobe: leading edge in phase 0, trailing edge in phase 1
    assign samp_now = enable_ff && (state_ff == ST_XFER) && !char_done &&
                      (is_master ? (half_tick && (!sck_phase_ff ^ cpha))
                                 : ((s_lead || s_trail) && (s_lead ^ cpha)));
    assign rx_strobe  = is_master ? samp_dly_ff[2] : samp_now;
    assign rx_capture = rx_strobe && (rx_cnt_ff == 3'h7);
    assign rx_char    = lsb ? {in_bit, rx_shift_ff[7:1]} : {rx_shift_ff[6:0], in_bit};

    // APB writes to configuration, control, select and data
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_ff      <= `REG_RESET;
            sel_mask_ff <= `REG_RESET;
            enable_ff   <= 1'b0;
            tx_hold_ff  <= `REG_RESET;
        end
        else if (wr_en)
        begin
            if (paddr == `ADDR_CONFIG)
                cfg_ff <= pwdata;
            else if (paddr == `ADDR_CTRL)
                enable_ff <= pwdata[`CTRL_ENABLE];
            else if (paddr == `ADDR_SELECT)
                sel_mask_ff <= pwdata;
            else if (paddr == `ADDR_DATA)
                tx_hold_ff <= pwdata;
        end
    end

    // Flags: hardware set beats software clear for receive ready and error; a data write beats tx_load
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_empty_ff <= 1'b0;
            rx_ready_ff <= 1'b0;
            error_ff    <= 1'b0;
            rx_hold_ff  <= `REG_RESET;
        end
        else
        begin
            // Transmit holding is free while idle-empty, loaded on write
            if (wr_en && (paddr == `ADDR_DATA))
                tx_empty_ff <= 1'b0;
            else if (tx_load)
                tx_empty_ff <= 1'b1;
            else if (!enable_ff)
                tx_empty_ff <= 1'b1;
            if (rx_capture)
            begin
                rx_hold_ff  <= rx_char;
                rx_ready_ff <= 1'b1;
                if (rx_ready_ff && !rd_data)
                    error_ff <= 1'b1;
            end
            else
            begin
                if (rd_data)
                    rx_ready_ff <= 1'b0;
                if (wr_en && (paddr == `ADDR_CTRL) && !pwdata[`CTRL_ERROR])
                    error_ff <= 1'b0;
            end
        end
    end

    // Transfer engine shared by both roles
    always @*
    begin
        tx_load = 1'b0;
        if (enable_ff && !tx_empty_ff && state_ff == ST_IDLE)
            tx_load = is_master || s_start || !s_sel_act;
    end

    // Master samples come through the miso synchroniser, so the strobe is
    // delayed three clocks to meet the bit that stood at the sample edge
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            samp_dly_ff <= 3'b000;
            rx_shift_ff <= `REG_RESET;
            rx_cnt_ff   <= 3'h0;
        end
        else if (!enable_ff)
        begin
            samp_dly_ff <= 3'b000;
            rx_cnt_ff   <= 3'h0;
        end
        else
        begin
            samp_dly_ff <= {samp_dly_ff[1:0], samp_now && is_master};
            if (!is_master && s_start && state_ff == ST_IDLE)
                rx_cnt_ff <= 3'h0;
            else if (rx_strobe)
            begin
                rx_shift_ff <= rx_char;
                rx_cnt_ff   <= rx_cnt_ff + 3'h1;
            end
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff     <= ST_IDLE;
            shift_ff     <= `REG_RESET;
            bit_cnt_ff   <= 4'h0;
            sck_phase_ff <= 1'b0;
        end
        else if (!enable_ff)
        begin
            state_ff     <= ST_IDLE;
            bit_cnt_ff   <= 4'h0;
            sck_phase_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    bit_cnt_ff   <= 4'h0;
                    sck_phase_ff <= 1'b0;
                    if (tx_load)
                    begin
                        shift_ff <= tx_hold_ff;
                        state_ff <= is_master ? ST_LEAD : ST_XFER;
                    end
                    else if (!is_master && s_start)
                    begin
                        // No new character: resend last holding value
                        shift_ff <= tx_hold_ff;
                        state_ff <= ST_XFER;
                    end
                end
                ST_LEAD:
                    // Half period with select low before the first clock edge
                    if (half_tick)
                        state_ff <= ST_XFER;
                ST_XFER:
                begin
                    if (char_done)
                    begin
                        // Phase 0 ends on its last trailing edge, phase 1 a half later
                        if (!is_master || half_tick)
                            state_ff <= ST_IDLE;
                    end
                    else if (is_master ? half_tick : (s_lead || s_trail))
                    begin
                        // Outgoing bit moves on at each sample edge
                        if (samp_now)
                        begin
                            shift_ff <= lsb ? {1'b0, shift_ff[7:1]}
                                            : {shift_ff[6:0], 1'b0};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                        if (is_master)
                            sck_phase_ff <= !sck_phase_ff;
                    end
                    if (!is_master && !s_sel_act)
                        state_ff <= ST_IDLE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
    // Pin drivers registered; inactive levels while disabled
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            m_sck   <= 1'b0;
            m_mosi  <= 1'b0;
            m_sel_n <= 8'hFF;
            s_miso  <= 1'b0;
        end
        else
        begin
            // Clock toggles once per half period, rests at polarity level while enabled, low while disabled
            if (enable_ff && is_master && state_ff == ST_XFER)
            begin
                if (half_tick && (!char_done || sck_phase_ff))
                    m_sck <= !m_sck;
            end
            else
                m_sck <= enable_ff && cfg_ff[`CFG_CPOL];
            m_mosi  <= enable_ff && is_master && busy && out_bit;
            // Mask gates select lines, only while a character is in flight
            m_sel_n <= (enable_ff && is_master && busy) ? ~sel_mask_ff
                                                        : 8'hFF;
            s_miso  <= enable_ff && !is_master && busy && out_bit;
        end
    end

    // Slave output driven only while selected and enabled (oe active low)
    assign s_miso_oe_n = !(enable_ff && !is_master && s_sel_act);

    // APB read mux; status shares offset with control
    always @*
    begin
        prdata = 8'h00;
        if (paddr == `ADDR_DATA)
            prdata = rx_hold_ff;
        else if (paddr == `ADDR_CONFIG)
            prdata = cfg_ff;
        else if (paddr == `ADDR_CTRL)
            prdata = {enable_ff, 3'b000, busy && is_master, tx_empty_ff,
                      rx_ready_ff, error_ff};
        else if (paddr == `ADDR_SELECT)
            prdata = sel_mask_ff;
    end

endmodule

// ===== spi_defs.vh
// Register offsets, field positions, reset values and character length of the serial controller
`ifndef SPI_DEFS_VH
`define SPI_DEFS_VH

`define ADDR_DATA       4'h0
`define ADDR_CONFIG     4'h4
`define ADDR_CTRL       4'h8
`define ADDR_SELECT     4'hC

`define CFG_IRQ_EN      7
`define CFG_MASTER      6
`define CFG_LSB_FIRST   5
`define CFG_CPHA        4
`define CFG_CPOL        3
`define CFG_RATE_HI     2

`define CTRL_ENABLE     7
`define CTRL_ERROR      0

`define ST_ENABLE       7
`define ST_BUSY         3
`define ST_TX_EMPTY     2
`define ST_RX_READY     1
`define ST_ERROR        0

`define REG_RESET       8'h00
`define CHAR_BITS       4'h8

`endif

// ===== clk_divider.v
// Divider giving a one-cycle toggle enable at half the selected serial clock period
`timescale 1ns/1ns
module clk_divider
(
    // Clock and reset
    input  wire       clk,
    input  wire       nrst,
    // Control
    input  wire       run,
    input  wire [2:0] rate,
    // Enable pulse, one per serial clock half period
    output wire       half_tick
);

    reg  [6:0] cnt_ff;
    wire [6:0] limit;

    // Half period is 2^rate system clocks: code 0 gives divide by 2
    assign limit = (7'h01 << rate) - 7'h01;
    assign half_tick = run && (cnt_ff >= limit);

    // Counter restarts whenever idle so the first half period is always full
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_ff <= 7'h00;
        else if (!run || half_tick)
            cnt_ff <= 7'h00;
        else
            cnt_ff <= cnt_ff + 7'h01;
    end

endmodule

// ===== spi_ctrl_sva.sv
// Port-level assertions for the serial controller
`timescale 1ns/1ns
module spi_ctrl_sva
(
    // Clock and reset
    input wire       clk,
    input wire       nrst,
    // Register port
    input wire       psel,
    input wire       penable,
    input wire       pwrite,
    input wire [3:0] paddr,
    input wire [7:0] pwdata,
    input wire [7:0] prdata,
    // Flags and pins
    input wire       tx_reg_empty,
    input wire       rx_data_ready,
    input wire       irq,
    input wire       master_mode,
    input wire       m_sck,
    input wire [7:0] m_sel_n,
    input wire       s_miso_oe_n
);
    reg  [7:0] cfg_ff;
    reg  [7:0] mask_ff;
    reg        en_ff;
    wire       wr = psel && penable && pwrite;
    wire       rd = psel && penable && !pwrite;

    // Shadows of the config, select and enable registers, taken on the same edge as the design
    always @(posedge clk or negedge nrst)
        if (!nrst)
            {cfg_ff, mask_ff, en_ff} <= 17'h00000;
        else if (wr && paddr == 4'h4)
            cfg_ff <= pwdata;
        else if (wr && paddr == 4'hC)
            mask_ff <= pwdata;
        else if (wr && paddr == 4'h8)
            en_ff <= pwdata[7];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_irq_gate: assert property (
        irq == (cfg_ff[7] && (tx_reg_empty || rx_data_ready)))
        else $error("irq disagrees with enable and flags");
    a_role_pin: assert property (
        master_mode == cfg_ff[6])
        else $error("master_mode disagrees with config");
    a_select_mask: assert property (
        (~m_sel_n & ~mask_ff) == 8'h00)
        else $error("select line low outside the mask");
    // Four quiet cycles give the clock time to settle after the last edge
    a_idle_clock: assert property (
        (en_ff && master_mode && mask_ff != 8'h00 && m_sel_n == 8'hFF && $stable(cfg_ff)) [*4]
        |-> m_sck == cfg_ff[3])
        else $error("serial clock not at rest level");
    a_cfg_readback: assert property (
        rd && paddr == 4'h4 |-> prdata == cfg_ff)
        else $error("config read differs from last write");
    a_unmapped_zero: assert property (
        rd && paddr[1:0] != 2'b00 |-> prdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_fields: assert property (
        rd && paddr == 4'h8 |-> prdata[7] == en_ff && prdata[6:4] == 3'h0
        && prdata[2:1] == {tx_reg_empty, rx_data_ready})
        else $error("status fields disagree with flags");
    a_read_clears: assert property (
        rd && paddr == 4'h0 |=> !rx_data_ready)
        else $error("receive ready stays after data read");
    a_disabled_quiet: assert property (
        !en_ff && !$past(en_ff) |-> m_sel_n == 8'hFF && s_miso_oe_n)
        else $error("pins active while disabled");

    c_master_frame: cover property (m_sel_n == 8'hFE);
    c_overrun: cover property (rd && paddr == 4'h8 && prdata[0]);
    c_irq_raised: cover property (irq && cfg_ff[7]);
endmodule

// ===== spi_target.sv
// Behavioural serial target answering on the master pins
`timescale 1ns/1ns
module spi_target
(
    // Serial pins
    input  wire       sck,
    input  wire       sel_n,
    input  wire       mosi,
    output reg        miso,
    // Format and data
    input  wire       cpol,
    input  wire       cpha,
    input  wire       lsb,
    input  wire [7:0] tx,
    output reg  [7:0] rx
);
    integer oi = 0;
    integer ii = 0;

    // Next bit out; stops after eight
    task put;
    begin
        if (oi < 8)
            miso = lsb ? tx[oi] : tx[7 - oi];
        oi = oi + 1;
    end
    endtask

    initial
        miso = 1'b0;
    // Frame start; in phase 0 the first bit must stand before the first edge
    always @(negedge sel_n)
    begin
        oi = 0;
        ii = 0;
        if (!cpha)
            put;
    end
    // A released line shows the inverse, so a stale copy cannot pass
    always @(posedge sel_n)
        miso = ~miso;
    // Leading edge samples in phase 0 and shifts in phase 1
    always @(sck)
        if (sel_n === 1'b0 && ((sck !== cpol) ^ cpha))
        begin
            rx[lsb ? ii : 7 - ii] = mosi;
            ii = ii + 1;
        end
        else if (sel_n === 1'b0)
            put;
endmodule

// ===== testbench.sv
// Bench driving the controller in master role with a target on select line 0
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
`define WAITF(c) begin for (k = 0; k < 9000 && !(c); k++) begin @(posedge clk); #1; end \
    if (k == 9000) begin err_count++; end_of_test; end end
module testbench;
    // Clock, reset and register port
    reg        clk;
    reg        nrst;
    reg        psel;
    reg        penable;
    reg        pwrite;
    reg  [3:0] paddr;
    reg  [7:0] pwdata;
    wire [7:0] prdata;
    // Flags and serial pins
    wire       tx_reg_empty;
    wire       rx_data_ready;
    wire       irq;
    wire       master_mode;
    wire       m_miso;
    wire       m_mosi;
    wire       m_sck;
    wire [7:0] m_sel_n;
    // Target format, data and bench state
    reg        cpol;
    reg        cpha;
    reg        lsb;
    reg  [7:0] ptx;
    wire [7:0] prx;
    reg  [7:0] rd_q;
    reg        lvl;
    integer    err_count;
    integer    checked;
    integer    k;
    integer    i;

    // Slave pins held idle: only the master role is exercised here
    spi_ctrl uut
    (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .tx_reg_empty(tx_reg_empty),
        .rx_data_ready(rx_data_ready), .irq(irq), .master_mode(master_mode),
        .m_miso(m_miso), .m_mosi(m_mosi), .m_sck(m_sck), .m_sel_n(m_sel_n),
        .s_sck(1'b0), .s_sel_n(1'b1), .s_mosi(1'b0), .s_miso(), .s_miso_oe_n()
    );
    spi_target target
    (
        .sck(m_sck), .sel_n(m_sel_n[0]), .mosi(m_mosi), .miso(m_miso),
        .cpol(cpol), .cpha(cpha), .lsb(lsb), .tx(ptx), .rx(prx)
    );

    // Free-running system clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Read data is taken at the edge that completes the access
    always @(posedge clk)
        if (psel && penable)
            rd_q <= prdata;

    // One access: setup, access, then an idle cycle so strobes never toggle twice at once
    task apb(input [3:0] a, input w, input [7:0] d);
    begin
        psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(posedge clk);
        #1 penable = 1'b1;
        @(posedge clk);
        #1 psel = 1'b0;
        penable = 1'b0;
        @(posedge clk);
        #1;
    end
    endtask
    task rd_chk(input [3:0] a, input [7:0] e);
    begin
        apb(a, 1'b0, 8'h00);
        `CHK("prdata", e, rd_q)
    end
    endtask
    // One character: select, clock rate, busy, final status and what the target saw
    task xfer(input [7:0] d, input integer h, input [7:0] st);
    begin
        apb(4'h0, 1'b1, d);
        `WAITF(m_sel_n !== 8'hFF)
        `CHK("m_sel_n", 8'hFE, m_sel_n)
        lvl = m_sck;
        `WAITF(m_sck !== lvl)
        lvl = m_sck;
        `WAITF(m_sck !== lvl)
        `CHK("half_period", h, k)
        apb(4'h8, 1'b0, 8'h00);
        `CHK("busy", 1'b1, rd_q[3])
        `WAITF(m_sel_n === 8'hFF)
        `WAITF(rx_data_ready === 1'b1)
        rd_chk(4'h8, st);
        `CHK("target_rx", d, prx)
    end
    endtask

    task t_reset;
    begin
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h4, 8'h00);
        rd_chk(4'h8, 8'h04);
        rd_chk(4'hC, 8'h00);
        `CHK("m_sel_n", 8'hFF, m_sel_n)
        $display("test reset done");
    end
    endtask
    task t_regs;
    begin
        apb(4'h4, 1'b1, 8'h5A);
        rd_chk(4'h4, 8'h5A);
        `CHK("master_mode", 1'b1, master_mode)
        apb(4'hC, 1'b1, 8'hA5);
        rd_chk(4'hC, 8'hA5);
        rd_chk(4'h1, 8'h00);
        apb(4'h8, 1'b1, 8'h7E);
        rd_chk(4'h8, 8'h04);
        `CHK("irq", 1'b0, irq)
        apb(4'h4, 1'b1, 8'hDA);
        `CHK("irq", 1'b1, irq)
        apb(4'h8, 1'b1, 8'h81);
        rd_chk(4'h8, 8'h84);
        $display("test registers done");
    end
    endtask
    // Every rate code, each with its own order, phase and polarity
    task t_xfer;
    begin
        for (i = 0; i < 8; i++)
        begin
            {lsb, cpha, cpol} = i[2:0];
            ptx = 8'hC6 + i[7:0];
            apb(4'h8, 1'b1, 8'h00);
            apb(4'h4, 1'b1, {2'b01, i[2:0], i[2:0]});
            apb(4'hC, 1'b1, 8'h01);
            apb(4'h8, 1'b1, 8'h81);
            apb(4'h8, 1'b1, 8'h80);
            `CHK("m_sck_idle", cpol, m_sck)
            xfer(8'h35 ^ i[7:0], 1 << i, 8'h86);
            rd_chk(4'h0, ptx);
        end
        $display("test transfers done");
    end
    endtask
    // Second character lands unread: flag sets, writing 1 keeps it, writing 0 clears
    task t_overrun;
    begin
        {lsb, cpha, cpol} = 3'b000;
        apb(4'h4, 1'b1, 8'h40);
        ptx = 8'h3C;
        xfer(8'h11, 1, 8'h86);
        ptx = 8'h96;
        xfer(8'h22, 1, 8'h87);
        apb(4'h8, 1'b1, 8'h81);
        rd_chk(4'h8, 8'h87);
        apb(4'h8, 1'b1, 8'h80);
        rd_chk(4'h8, 8'h86);
        rd_chk(4'h0, 8'h96);
        $display("test overrun done");
    end
    endtask
    // A write while disabled must not start a frame
    task t_disable;
    begin
        apb(4'h8, 1'b1, 8'h00);
        apb(4'h0, 1'b1, 8'h5C);
        repeat (64) @(posedge clk);
        #1;
        `CHK("m_sel_n", 8'hFF, m_sel_n)
        rd_chk(4'h8, 8'h04);
        $display("test disable done");
    end
    endtask

    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // Reset for three cycles, then the scenarios in order
    initial
    begin
        err_count = 0;
        checked = 0;
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = 15'h0000;
        {cpol, cpha, lsb, ptx} = 11'h000;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        @(posedge clk);
        #1;
        t_reset;
        t_regs;
        t_xfer;
        t_overrun;
        t_disable;
        end_of_test;
    end
endmodule

bind spi_ctrl spi_ctrl_sva chk
(
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .tx_reg_empty(tx_reg_empty),
    .rx_data_ready(rx_data_ready), .irq(irq), .master_mode(master_mode),
    .m_sck(m_sck), .m_sel_n(m_sel_n), .s_miso_oe_n(s_miso_oe_n)
);
